// ==== bench/testbench.sv ====
// Self-checking testbench for the control block
module testbench;
  import ttl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       txd = 1'b1;
  logic       e1 = 1'b0;
  logic       resp = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] d;
  logic       tick, seen, txb, pwr, dl, al, rl, gl;
  logic [9:0] hist;
  int         n, n_fail = 0, check_count = 0;
  always #2.5 clk = ~clk;
  ttl_ctrl ttl_ctrl_i (.i_core_clk(clk), .i_resetn(rstn),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_e1_mode(e1), .i_tx_data(txd),
    .i_bit_tick(tick), .i_loop_code_seen(seen), .o_tx_bit(txb),
    .o_transmitter_power_on(pwr), .o_dual_loopback(dl),
    .o_analog_loopback(al), .o_remote_loopback(rl),
    .o_digital_loopback(gl));
  ttl_far_end ttl_far_end_i (.i_core_clk(clk), .i_tx_bit(txb),
    .i_respond(resp), .o_bit_tick(tick), .o_loop_code_seen(seen),
    .o_hist(hist), .o_n(n));
  task print_verdict;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wreg(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task rreg(input logic [4:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  // Select a pattern just after a tick, then capture k line bits
  // Skips the bit launched at the tick before the write
  task send(input logic [7:0] v, input int k);
    int n0;
    while (tick !== 1'b1) @(negedge clk);
    wreg(ADDR_CTRL, v);
    n0 = n + 1;
    while (n < n0 + k) @(negedge clk);
  endtask : send
  task t_reset;
    rreg(ADDR_CTRL);
    chk(d, 10'h000);
    @(posedge clk);
    #1 chk(rdata, 10'h000);
    chk({pwr, dl, al, rl, gl}, 10'h000);
    rreg(5'h1F);
    chk(d, 10'h000);
  endtask : t_reset
  task t_loopback;
    for (int v = 0; v < 8; v++)
    begin
      wreg(ADDR_CTRL, 8'(v) | 8'h08);
      repeat (2) @(posedge clk);
      #1 chk({dl, al, rl, gl}, v[2] ? 10'h8 >> v[1:0] : 10'h0);
      chk(pwr, 10'h001);
      rreg(ADDR_CTRL);
      chk(d, 10'(v | 8));
    end
    wreg(5'h04, 8'hFF);
    rreg(ADDR_CTRL);
    chk(d, 10'h00F);
    rreg(5'h1F);
    chk(d, 10'h000);
  endtask : t_loopback
  task t_codes;
    wreg(ADDR_DETECT, 8'hC0);
    resp <= 1'b1;
    rreg(ADDR_DETECT);
    chk(d, 10'h0C0);
    send(8'h20, 10);
    chk(hist, 10'h021);
    chk(rl, 10'h000);
    send(8'h30, 9);
    chk(hist[8:0], 10'h049);
    chk(rl, 10'h001);
    @(posedge clk);
    resp <= 1'b0;
    send(8'h00, 10);
    chk(hist, 10'h3FF);
  endtask : t_codes
  // PRBS in each line mode: zero runs capped, both levels present
  task t_prbs;
    int run, worst, ones, n1;
    for (int m = 0; m < 2; m++)
    begin
      run = 0;
      worst = 0;
      ones = 0;
      @(posedge clk);
      e1 <= 1'(m);
      send(8'h40, 1);
      repeat (200)
      begin
        n1 = n;
        while (n == n1) @(negedge clk);
        run = hist[0] ? 0 : run + 1;
        ones += int'(hist[0]);
        if (run > worst)
          worst = run;
      end
      chk(10'(worst > MAX_ZEROS), 10'h000);
      chk(10'(ones > 0 && ones < 200), 10'h001);
    end
    send(8'h50, 20);
  endtask : t_prbs
  initial
  begin
    #200us;
    n_fail++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_loopback();
    t_codes();
    t_prbs();
    print_verdict();
  end
endmodule : testbench

// ==== bench/ttl_far_end.sv ====
// Far-end terminal model: bit timing, line capture, loop response
module ttl_far_end (
  input  wire logic       i_core_clk,
  input  wire logic       i_tx_bit,
  input  wire logic       i_respond,
  output logic            o_bit_tick,
  output logic            o_loop_code_seen,
  output logic [9:0]      o_hist,
  output int              o_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt = 2'h0;
  logic [9:0] hist = 10'h000;
  int         n_bits = 0;
  assign o_bit_tick = (cnt == 2'h0);
  assign o_loop_code_seen = i_respond;
  assign o_hist = hist;
  assign o_n = n_bits;
  // Capture each line bit mid-period
  always @(posedge i_core_clk)
  begin
    cnt <= cnt + 2'h1;
    if (cnt == 2'h2)
    begin
      hist <= {hist[8:0], i_tx_bit};
      n_bits <= n_bits + 1;
    end
  end
endmodule : ttl_far_end

// ==== rtl/ttl_ctrl.sv ====
// Transmit test pattern and loopback control register block
module ttl_ctrl
  import ttl_pkg::*;
(
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_resetn,
  // Register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [REG_W-1:0]  i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [REG_W-1:0]  o_rdata,
  // Line side
  input  wire logic              i_e1_mode,
  input  wire logic              i_tx_data,
  input  wire logic              i_bit_tick,
  input  wire logic              i_loop_code_seen,
  output logic                   o_tx_bit,
  output logic                   o_transmitter_power_on,
  // Loopback selection
  output logic                   o_dual_loopback,
  output logic                   o_analog_loopback,
  output logic                   o_remote_loopback,
  output logic                   o_digital_loopback
);
  logic [REG_W-1:0] ctrl;
  logic [1:0]       detect_en;
  logic [2:0]       code_idx;
  logic [19:0]      prbs;
  logic [3:0]       zero_run;
  logic             e1_meta, e1_sync, seen_meta, seen_sync;
  logic             err_armed;
  logic [REG_W-1:0] next_rdata;
  logic             next_tx_bit;

  // Pin synchronisers
  always_ff @(posedge i_core_clk)
  begin
    e1_meta   <= i_e1_mode;
    e1_sync   <= e1_meta;
    seen_meta <= i_loop_code_seen;
    seen_sync <= seen_meta;
  end

  // Field decode
  wire [2:0] pat_sel = {ctrl[POS_PAT_HI], ctrl[POS_PAT_MID],
                        ctrl[POS_PAT_LOW]};
  wire       send_loop_up_code   = (pat_sel == PAT_LOOP_UP);
  wire       send_loop_down_code = (pat_sel == PAT_LOOP_DOWN);
  wire       send_prbs_pattern   = pat_sel[2];
  wire       invert_prbs_pattern = pat_sel[2] & pat_sel[0];
  wire       inject_single_bit_error = pat_sel[2] & pat_sel[1];
  wire       loopback_sel_top = ctrl[POS_LOOP_TOP];
  wire [1:0] loopback_sel_low2 = ctrl[POS_LOOP_TOP-1:0];
  wire       wr_ctrl   = i_wr & (i_addr == ADDR_CTRL);
  wire       wr_detect = i_wr & (i_addr == ADDR_DETECT);
  // Selector change restarts any loop code at its first bit
  wire       sel_change = wr_ctrl
                          & (i_wdata[POS_PAT_HI:POS_PAT_LOW] != pat_sel);
  wire       loop_code = send_loop_up_code | send_loop_down_code;
  wire [2:0] code_last = send_loop_up_code ? 3'(LOOP_UP_LEN - 1)
                                           : 3'(LOOP_DOWN_LEN - 1);
  wire       code_bit  = send_loop_up_code
                         ? LOOP_UP_CODE[3'(LOOP_UP_LEN - 1) - code_idx]
                         : LOOP_DOWN_CODE[2'(LOOP_DOWN_LEN - 1)
                                          - 2'(code_idx)];
  wire       prbs_fb   = e1_sync ? prbs[PRBS_E1_LEN-1] ^ prbs[PRBS_E1_TAP-1]
                                 : prbs[PRBS_T1_LEN-1] ^ prbs[PRBS_T1_TAP-1];
  wire       prbs_out  = (!e1_sync && zero_run >= 4'(MAX_ZEROS)) | prbs_fb;

  // Loopback mode decode
  function automatic ttl_lb_type lb_decode(input logic top,
                                           input logic [1:0] low);
    if (!top)
      return LB_NONE;
    case (low)
      2'h0:    return LB_DUAL;
      2'h1:    return LB_ANALOG;
      2'h2:    return LB_REMOTE;
      default: return ttl_lb_type'(4'h0);
    endcase
  endfunction : lb_decode
  wire ttl_lb_type lb_mode = lb_decode(loopback_sel_top,
                                       loopback_sel_low2);
  wire       digital_sel = loopback_sel_top & (&loopback_sel_low2);
  // Auto remote loopback blocked while sending loop-up
  wire       auto_ok = (&detect_en) & ~send_loop_up_code;

  always_comb
  begin
    next_rdata = '0;
    if (i_rd && i_addr == ADDR_CTRL)
      next_rdata = ctrl;
    else if (i_rd && i_addr == ADDR_DETECT)
      next_rdata = {detect_en, 6'h00};
  end

  always_comb
  begin
    next_tx_bit = i_tx_data;
    if (loop_code)
      next_tx_bit = code_bit;
    else if (send_prbs_pattern)
      next_tx_bit = prbs_out ^ invert_prbs_pattern ^ (inject_single_bit_error
                    & err_armed);
  end

  // Registers
  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      ctrl      <= CTRL_RESET;
      detect_en <= DETECT_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= i_wdata;
      if (wr_detect)
        detect_en <= i_wdata[REG_W-1:REG_W-2];
    end
  end

  // Pattern generators
  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      code_idx  <= '0;
      prbs      <= PRBS_SEED;
      zero_run  <= '0;
      err_armed <= 1'b0;
    end
    else
    begin
      if (!loop_code || sel_change)
        code_idx <= '0;
      else if (i_bit_tick)
        code_idx <= (code_idx >= code_last) ? 3'h0
                                            : code_idx + 3'h1;
      if (i_bit_tick && send_prbs_pattern)
      begin
        prbs     <= {prbs[18:0], prbs_fb};
        zero_run <= prbs_out ? 4'h0 : zero_run + 4'h1;
      end
      if (wr_ctrl)
        err_armed <= 1'b1;
      else if (i_bit_tick)
        err_armed <= 1'b0;
    end
  end

  // Outputs
  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      o_rdata                <= '0;
      o_tx_bit               <= 1'b0;
      o_transmitter_power_on <= 1'b0;
      o_dual_loopback        <= 1'b0;
      o_analog_loopback      <= 1'b0;
      o_remote_loopback      <= 1'b0;
      o_digital_loopback     <= 1'b0;
    end
    else
    begin
      o_rdata                <= next_rdata;
      if (i_bit_tick)
        o_tx_bit             <= next_tx_bit;
      o_transmitter_power_on <= ctrl[POS_TX_ON];
      o_dual_loopback        <= (lb_mode == LB_DUAL);
      o_analog_loopback      <= (lb_mode == LB_ANALOG);
      o_remote_loopback      <= (lb_mode == LB_REMOTE)
                                | (auto_ok & seen_sync);
      o_digital_loopback     <= digital_sel;
    end
  end

  // Loop-up selected with no manual loopback
  sequence s_upcode_no_lb;
    send_loop_up_code && !loopback_sel_top;
  endsequence

  a_upcode_blocks: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    s_upcode_no_lb [*2] |-> !o_remote_loopback)
    else $error("remote loopback while sending loop-up");
  a_upcode_bits: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    (send_loop_up_code && $stable(pat_sel) && i_bit_tick) |=>
      o_tx_bit == ($past(code_idx) == 3'(LOOP_UP_LEN - 1)))
    else $error("loop-up bit wrong");
  a_downcode_wrap: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    (send_loop_down_code && i_bit_tick && code_idx == 3'h2 && !wr_ctrl)
      |=> code_idx == 3'h0)
    else $error("loop-down sequence not repeating");
  a_lb_onehot: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    !loopback_sel_top [*2] |-> !o_dual_loopback && !o_analog_loopback
      && !o_digital_loopback)
    else $error("loopback active with top bit clear");
  a_digital_sel: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    $past(digital_sel) |-> o_digital_loopback)
    else $error("digital loopback missing");
  a_ctrl_write: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    wr_ctrl |=> pat_sel == $past(i_wdata[POS_PAT_HI:POS_PAT_LOW]))
    else $error("selector not written");
  a_zero_limit: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    !e1_sync |-> zero_run <= 4'(MAX_ZEROS))
    else $error("too many zeros");
  a_prbs_inv: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    (pat_sel == 3'h5 && i_bit_tick && !err_armed) |=>
      o_tx_bit == !$past(prbs_out))
    else $error("inverted prbs wrong");
endmodule : ttl_ctrl

// ==== rtl/ttl_pkg.sv ====
// Constants for the transmit test and loopback control block
package ttl_pkg;
  localparam int          REG_W            = 8;
  localparam int          ADDR_W           = 5;
  // Register addresses
  localparam logic [4:0]  ADDR_CTRL        = 5'h02;
  localparam logic [4:0]  ADDR_DETECT      = 5'h03;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [1:0]  DETECT_RESET     = 2'h0;
  // Field positions in the control register
  localparam int          POS_PAT_HI       = 6;
  localparam int          POS_PAT_MID      = 5;
  localparam int          POS_PAT_LOW      = 4;
  localparam int          POS_TX_ON        = 3;
  localparam int          POS_LOOP_TOP     = 2;
  // Pattern selector codes
  localparam logic [2:0]  PAT_LOOP_UP      = 3'h2;
  localparam logic [2:0]  PAT_LOOP_DOWN    = 3'h3;
  // Loop codes, sent MSB first
  localparam logic [4:0]  LOOP_UP_CODE     = 5'h01;
  localparam int          LOOP_UP_LEN      = 5;
  localparam logic [2:0]  LOOP_DOWN_CODE   = 3'h1;
  localparam int          LOOP_DOWN_LEN    = 3;
  // PRBS lengths and zero limit
  localparam int          PRBS_T1_LEN      = 20;
  localparam int          PRBS_E1_LEN      = 15;
  localparam int          PRBS_T1_TAP      = 17;
  localparam int          PRBS_E1_TAP      = 14;
  localparam int          MAX_ZEROS        = 14;
  localparam logic [19:0] PRBS_SEED        = 20'hFFFFF;
  typedef enum logic [3:0] {
    LB_NONE    = 4'h1,
    LB_DUAL    = 4'h2,
    LB_ANALOG  = 4'h4,
    LB_REMOTE  = 4'h8
  } ttl_lb_type;
endpackage : ttl_pkg
